// ---- hw/radio_irq_mask_source_unit.sv ----
`timescale 1ns/1ps
module radio_irq_mask_source_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [irq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [irq_pkg::DATA_W-1:0] reg_wdata,
  output logic [irq_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // MAC-level event pulses
  input wire logic wakeup_count_hit,
  input wire logic smart_wake_level_hit,
  input wire logic cipher_done,
  input wire logic cipher_loaded,
  input wire logic tx_packet_done,
  input wire logic rx_addr_match,
  input wire logic rx_crc_ok,
  input wire logic rx_sync_found,
  input wire logic rx_preamble_found,
  // PHY-level event pulses
  input wire logic battery_low,
  input wire logic cmd_ready,
  input wire logic wake_timer_expired,
  input wire logic port_ready,
  input wire logic cmd_done,
  // Interrupt outputs
  output logic irq_out_pin,
  output logic status_irq
);
  import irq_pkg::*;

  irq_bank_if mac_en_if ();
  irq_bank_if phy_en_if ();
  irq_bank_if mac_fl_if ();
  irq_bank_if phy_fl_if ();

  logic hit_mac_en;
  logic hit_phy_en;
  logic hit_mac_fl;
  logic hit_phy_fl;
  logic [7:0] mac_ev;
  logic [7:0] phy_ev;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic irq_r;

  // Address decode
  always_comb begin
    hit_mac_en = (reg_addr == MAC_IRQ_ENABLE_OFS);
    hit_phy_en = (reg_addr == PHY_IRQ_ENABLE_OFS);
    hit_mac_fl = (reg_addr == MAC_IRQ_FLAGS_OFS);
    hit_phy_fl = (reg_addr == PHY_IRQ_FLAGS_OFS);
  end

  // MAC event map; cipher done counts only with its firmware loaded
  always_comb begin
    mac_ev = 8'h00;
    mac_ev[MAC_WAKEUP_COUNT_BIT] = wakeup_count_hit;
    mac_ev[MAC_SMART_WAKE_BIT] = smart_wake_level_hit;
    mac_ev[MAC_CIPHER_DONE_BIT] = cipher_done & cipher_loaded;
    mac_ev[MAC_TX_DONE_BIT] = tx_packet_done;
    mac_ev[MAC_ADDR_MATCH_BIT] = rx_addr_match;
    mac_ev[MAC_CRC_OK_BIT] = rx_crc_ok;
    mac_ev[MAC_SYNC_BIT] = rx_sync_found;
    mac_ev[MAC_PREAMBLE_BIT] = rx_preamble_found;
  end

  // PHY event map; reserved positions stay zero
  always_comb begin
    phy_ev = 8'h00;
    phy_ev[PHY_BATTERY_BIT] = battery_low;
    phy_ev[PHY_CMD_READY_BIT] = cmd_ready;
    phy_ev[PHY_WAKE_TIMER_BIT] = wake_timer_expired;
    phy_ev[PHY_PORT_READY_BIT] = port_ready;
    phy_ev[PHY_CMD_DONE_BIT] = cmd_done;
  end

  // Enable register strobes
  assign mac_en_if.wr = reg_wr_en & hit_mac_en;
  assign mac_en_if.wdata = reg_wdata;
  assign mac_en_if.ev = 8'h00;
  assign phy_en_if.wr = reg_wr_en & hit_phy_en;
  assign phy_en_if.wdata = reg_wdata;
  assign phy_en_if.ev = 8'h00;

  // Flag register strobes; same bit layout as enables
  assign mac_fl_if.wr = reg_wr_en & hit_mac_fl;
  assign mac_fl_if.wdata = reg_wdata;
  assign mac_fl_if.ev = mac_ev;
  assign phy_fl_if.wr = reg_wr_en & hit_phy_fl;
  assign phy_fl_if.wdata = reg_wdata;
  assign phy_fl_if.ev = phy_ev;

  irq_enable_reg #(.VALID_BITS(MAC_VALID_BITS)) u_mac_en (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(mac_en_if.mask)
  );

  irq_enable_reg #(.VALID_BITS(PHY_VALID_BITS)) u_phy_en (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(phy_en_if.mask)
  );

  // Sticky flags hold each pulse until written with 1
  irq_flag_bank #(.VALID_BITS(MAC_VALID_BITS)) u_mac_fl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(mac_fl_if.flag)
  );

  irq_flag_bank #(.VALID_BITS(PHY_VALID_BITS)) u_phy_fl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(phy_fl_if.flag)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (1'b1)
      hit_mac_en: rdata_nxt = mac_en_if.q;
      hit_phy_en: rdata_nxt = phy_en_if.q;
      hit_mac_fl: rdata_nxt = mac_fl_if.q;
      hit_phy_fl: rdata_nxt = phy_fl_if.q;
      default: rdata_nxt = RDATA_RST;
    endcase
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= RDATA_RST;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // Masked OR of both banks; only an observer, never feeds back
  always_comb begin
    irq_nxt = |(mac_fl_if.q & mac_en_if.q)
      | |(phy_fl_if.q & phy_en_if.q);
  end

  // Pin stays high while any enabled flag is left pending
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Pin and status bit are the same level for pin or polling hosts
  assign irq_out_pin = irq_r;
  assign status_irq = irq_r;
endmodule

// ---- hw/irq_pkg.sv ----
package irq_pkg;

  // Register offsets on the register port
  localparam logic [11:0] MAC_IRQ_ENABLE_OFS = 12'h0100;
  localparam logic [11:0] PHY_IRQ_ENABLE_OFS = 12'h0101;
  localparam logic [11:0] MAC_IRQ_FLAGS_OFS = 12'h0336;
  localparam logic [11:0] PHY_IRQ_FLAGS_OFS = 12'h0337;

  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Values after reset
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Bit positions of the MAC-level sources
  localparam int MAC_WAKEUP_COUNT_BIT = 7;
  localparam int MAC_SMART_WAKE_BIT = 6;
  localparam int MAC_CIPHER_DONE_BIT = 5;
  localparam int MAC_TX_DONE_BIT = 4;
  localparam int MAC_ADDR_MATCH_BIT = 3;
  localparam int MAC_CRC_OK_BIT = 2;
  localparam int MAC_SYNC_BIT = 1;
  localparam int MAC_PREAMBLE_BIT = 0;

  // Bit positions of the PHY-level sources
  localparam int PHY_BATTERY_BIT = 7;
  localparam int PHY_CMD_READY_BIT = 6;
  localparam int PHY_WAKE_TIMER_BIT = 4;
  localparam int PHY_PORT_READY_BIT = 1;
  localparam int PHY_CMD_DONE_BIT = 0;

  // Implemented bits of each bank; reserved PHY bits 5, 3, 2 read zero
  localparam logic [7:0] MAC_VALID_BITS = 8'hFF;
  localparam logic [7:0] PHY_VALID_BITS = 8'hD3;

endpackage

// ---- hw/irq_bank_if.sv ----
`timescale 1ns/1ps
interface irq_bank_if;
  // Write strobe and data from the register port
  logic wr;
  logic [7:0] wdata;
  // Event pulses, one per bit
  logic [7:0] ev;
  // Stored register contents
  logic [7:0] q;

  modport ctrl (output wr, output wdata, output ev, input q);
  modport flag (input wr, input wdata, input ev, output q);
  modport mask (input wr, input wdata, output q);
endinterface

// ---- hw/irq_enable_reg.sv ----
`timescale 1ns/1ps
module irq_enable_reg #(
  parameter logic [7:0] VALID_BITS = 8'hFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register access
  irq_bank_if.mask bus
);
  import irq_pkg::*;

  logic [7:0] enable_r;

  // Plain read/write enable bits, reserved bits held at zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_r <= ENABLE_RST;
    end else if (bus.wr) begin
      enable_r <= bus.wdata & VALID_BITS;
    end
  end

  assign bus.q = enable_r;
endmodule

// ---- hw/irq_flag_bank.sv ----
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter logic [7:0] VALID_BITS = 8'hFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register access and events
  irq_bank_if.flag bus
);
  import irq_pkg::*;

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] clr_bits;

  // Write 1 clears; a new event in the same cycle keeps the bit set
  always_comb begin
    clr_bits = bus.wr ? bus.wdata : 8'h00;
    flags_nxt = ((flags_r & ~clr_bits) | bus.ev) & VALID_BITS;
  end

  // Sticky flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign bus.q = flags_r;
endmodule

// ---- tb/irq_unit_props.sv ----
`timescale 1ns/1ps
module irq_unit_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Event and interrupt
  input wire logic battery_low,
  input wire logic irq_out_pin,
  input wire logic status_irq
);
  logic bat_en_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Shadow of the battery enable bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) bat_en_r <= 1'b0;
    else if (reg_wr_en && reg_addr == 12'h0101) bat_en_r <= reg_wdata[7];
  end
  property p_rd_lat; reg_rd_valid == $past(reg_rd_en); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late valid");
  property p_pin; irq_out_pin == status_irq; endproperty
  a_pin: assert property (p_pin) else $error("pin vs status");
  property p_hold; !reg_rd_en |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_bat_flag;
    battery_low ##1 (reg_rd_en && reg_addr == 12'h0337) |=> reg_rdata[7];
  endproperty
  a_bat_flag: assert property (p_bat_flag) else $error("no flag");
  property p_resv;
    reg_rd_en && reg_addr == 12'h0337 |=> (reg_rdata & 8'h2C) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_unmap; reg_rd_en && reg_addr == 12'h0200 |=> !reg_rdata; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_fall; $fell(irq_out_pin) |-> $past(reg_wr_en, 2); endproperty
  a_fall: assert property (p_fall) else $error("pin dropped");
  property p_bat_pin;
    battery_low && bat_en_r && !reg_wr_en |-> ##2 irq_out_pin;
  endproperty
  a_bat_pin: assert property (p_bat_pin) else $error("pin missing");
  c_rise: cover property ($rose(irq_out_pin));
  c_fall: cover property ($fell(irq_out_pin));
  c_bat: cover property (battery_low ##1 reg_rd_en);
endmodule
bind radio_irq_mask_source_unit irq_unit_props u_irq_unit_props (.sys_clk,
  .arst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
  .reg_rd_valid, .battery_low, .irq_out_pin, .status_irq);

// ---- tb/irq_host_model.sv ----
`timescale 1ns/1ps
module irq_host_model (
  // Clock
  input wire logic sys_clk,
  // Register requests
  output logic [11:0] reg_addr = 12'h0000,
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  // Answers
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic irq_out_pin
);
  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask
  // One-cycle read strobe, answer taken a cycle later
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
  // Service on a raised pin: read flags, then clear what was seen
  task automatic service(input logic [11:0] a, output logic [7:0] d);
    logic v;
    d = 8'h00;
    if (irq_out_pin) begin
      rd(a, d, v);
      wr(a, d);
    end
  endtask
endmodule

// ---- tb/radio_irq_mask_source_unit_test.sv ----
`timescale 1ns/1ps
module radio_irq_mask_source_unit_test;
  import irq_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr, a;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, irq_out_pin, status_irq, v;
  logic [7:0] reg_wdata, reg_rdata, d, e;
  logic [12:0] ev = '0;
  logic cip_ld = 1'b1;
  int num_errors = 0;
  int checked = 0;
  int phyb[5] = '{0, 1, 4, 6, 7};
  logic [11:0] ofs[5] = '{MAC_IRQ_ENABLE_OFS, PHY_IRQ_ENABLE_OFS,
    MAC_IRQ_FLAGS_OFS, PHY_IRQ_FLAGS_OFS, 12'h0200};
  always #12.5 sys_clk = ~sys_clk;
  radio_irq_mask_source_unit u_radio_irq_mask_source_unit (.sys_clk,
    .arst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .reg_rd_valid, .wakeup_count_hit(ev[7]), .smart_wake_level_hit(ev[6]),
    .cipher_done(ev[5]), .cipher_loaded(cip_ld), .tx_packet_done(ev[4]),
    .rx_addr_match(ev[3]), .rx_crc_ok(ev[2]), .rx_sync_found(ev[1]),
    .rx_preamble_found(ev[0]), .battery_low(ev[12]), .cmd_ready(ev[11]),
    .wake_timer_expired(ev[10]), .port_ready(ev[9]), .cmd_done(ev[8]),
    .irq_out_pin, .status_irq);
  irq_host_model u_irq_host_model (.sys_clk, .reg_addr, .reg_wr_en,
    .reg_rd_en, .reg_wdata, .reg_rdata, .reg_rd_valid, .irq_out_pin);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    foreach (ofs[i]) begin
      u_irq_host_model.rd(ofs[i], d, v);
      chk(d, 8'h00);
      chk({7'h0, v}, 8'h01);
    end
    $display("test reset done");
    @(negedge sys_clk);
    ev = 13'h1000;
    u_irq_host_model.rd(PHY_IRQ_FLAGS_OFS, d, v);
    ev = '0;
    repeat (2) @(negedge sys_clk);
    chk(d, 8'h80);
    chk({7'h0, irq_out_pin}, 8'h00);
    u_irq_host_model.wr(PHY_IRQ_ENABLE_OFS, 8'hFF);
    u_irq_host_model.rd(PHY_IRQ_ENABLE_OFS, d, v);
    chk(d, 8'hD3);
    chk({7'h0, irq_out_pin}, 8'h01);
    u_irq_host_model.service(PHY_IRQ_FLAGS_OFS, d);
    repeat (2) @(negedge sys_clk);
    chk(d, 8'h80);
    chk({7'h0, irq_out_pin}, 8'h00);
    u_irq_host_model.wr(MAC_IRQ_ENABLE_OFS, 8'hFF);
    u_irq_host_model.rd(MAC_IRQ_ENABLE_OFS, d, v);
    chk(d, 8'hFF);
    $display("test mask done");
    for (int j = 0; j < 13; j++) begin
      e = j < 8 ? 8'h01 << j : 8'h01 << phyb[j - 8];
      a = j < 8 ? MAC_IRQ_FLAGS_OFS : PHY_IRQ_FLAGS_OFS;
      @(negedge sys_clk);
      ev = 13'h0001 << j;
      repeat (2) @(negedge sys_clk);
      ev = '0;
      chk({7'h0, status_irq}, 8'h01);
      u_irq_host_model.rd(a, d, v);
      chk(d, e);
      u_irq_host_model.wr(a, e);
      repeat (2) @(negedge sys_clk);
      chk({7'h0, irq_out_pin}, 8'h00);
    end
    $display("test events done");
    // Cipher done without its firmware loaded must leave no flag
    @(negedge sys_clk);
    cip_ld = 1'b0;
    ev = 13'h0020;
    @(negedge sys_clk);
    ev = '0;
    cip_ld = 1'b1;
    u_irq_host_model.rd(MAC_IRQ_FLAGS_OFS, d, v);
    chk(d, 8'h00);
    $display("test cipher gate done");
    @(negedge sys_clk);
    ev = 13'h00FF;
    @(negedge sys_clk);
    ev = '0;
    u_irq_host_model.wr(MAC_IRQ_FLAGS_OFS, 8'hFF);
    u_irq_host_model.rd(MAC_IRQ_FLAGS_OFS, d, v);
    chk(d, 8'h00);
    $display("test clear all done");
    test_done();
  end
endmodule
